// ===== common/swc_pkg.sv
// shared constants and types for the sleep and wake controller
package swc_pkg;
  localparam int CLK_PERIOD_NS   = 8;
  localparam int TICK_NS         = 1000000;
  localparam int TICK_CYCLES_DEF = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W          = 17;
  localparam int CHECK_WINDOW_MS = 30;
  localparam int REJOIN_MS       = 160;
  localparam int TIMER_W         = 16;
  localparam int OWED_W          = 4;
  localparam int SETTLE_W        = 2;

  localparam logic [TIMER_W-1:0]  MS_ZERO     = 16'h0000;
  localparam logic [TIMER_W-1:0]  MS_ONE      = 16'h0001;
  localparam logic [TIMER_W-1:0]  CHECK_MS    = TIMER_W'(CHECK_WINDOW_MS);
  localparam logic [TIMER_W-1:0]  REJOIN_TMO  = TIMER_W'(REJOIN_MS);
  localparam logic [TICK_W-1:0]   TICK_ZERO   = 17'h00000;
  localparam logic [TICK_W-1:0]   TICK_ONE    = 17'h00001;
  localparam logic [OWED_W-1:0]   OWED_ZERO   = 4'h0;
  localparam logic [OWED_W-1:0]   OWED_ONE    = 4'h1;
  localparam logic [OWED_W-1:0]   OWED_TWO    = 4'h2;
  localparam logic [OWED_W-1:0]   OWED_MAX    = 4'hF;
  localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 2'h0;
  localparam logic [SETTLE_W-1:0] SETTLE_ONE  = 2'h1;
  localparam logic [SETTLE_W-1:0] SETTLE_DONE = 2'h3;
  localparam logic [7:0]          BYTE_ZERO   = 8'h00;

  // pin function value that hands a pin to its sleep or status role
  localparam logic [2:0] PIN_PERIPHERAL = 3'h1;

  // sleep_selection encodings
  localparam logic [1:0] SEL_NONE   = 2'h0;
  localparam logic [1:0] SEL_PIN    = 2'h1;
  localparam logic [1:0] SEL_CYCLIC = 2'h2;
  // sleep_option encodings
  localparam logic OPT_ASSOC = 1'b0;
  localparam logic OPT_DEEP  = 1'b1;

  typedef enum logic [6:0] {
    ST_INIT  = 7'h01,
    ST_AWAKE = 7'h02,
    ST_SLEEP = 7'h04,
    ST_DTIM  = 7'h08,
    ST_CHECK = 7'h10,
    ST_WAKE  = 7'h20,
    ST_ASSOC = 7'h40
  } swc_dev_state_type;

  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_WAKE = 3'h2,
    H_SEND = 3'h4
  } swc_host_state_type;
endpackage

// ===== common/swc_if.sv
// pins between the host microcontroller and the wireless module
`timescale 1ns/1ps
interface swc_if;
  logic       sleep_request_in;  // host: high asks for sleep
  logic       serial_select_n;   // host: spi slave select, low active
  logic       awake_indicator;   // device: high while awake
  logic       cts_n;             // device: clear to send, low active
  logic       attention_n;       // device: spi attention, low active
  logic       host_data_valid;   // host: byte strobe toward device
  logic [7:0] host_data;         // host: byte toward device
  logic       dev_data_valid;    // device: byte strobe toward host
  logic [7:0] dev_data;          // device: byte toward host

  modport device (
    input  sleep_request_in,
    input  serial_select_n,
    input  host_data_valid,
    input  host_data,
    output awake_indicator,
    output cts_n,
    output attention_n,
    output dev_data_valid,
    output dev_data
  );

  modport host (
    output sleep_request_in,
    output serial_select_n,
    output host_data_valid,
    output host_data,
    input  awake_indicator,
    input  cts_n,
    input  attention_n,
    input  dev_data_valid,
    input  dev_data
  );
endinterface

// ===== rtl/swc_host.sv
// host microcontroller end: drives sleep pins and moves bytes
`timescale 1ns/1ps
module swc_host
  import swc_pkg::*;
(
  input  wire logic       clk,           // 125 MHz clock
  input  wire logic       resetn,        // async reset, low active
  swc_if.host             link,          // pins to the module
  input  wire logic       spi_mode,      // serial link is spi
  input  wire logic       select_sleeps, // module sleeps on slave select
  input  wire logic       want_sleep,    // user wants module asleep
  input  wire logic       send_valid,    // user byte offered
  input  wire logic [7:0] send_byte,     // user byte
  output logic            send_ready,    // user byte taken
  output logic            recv_valid,    // byte from module
  output logic [7:0]      recv_byte      // byte from module
);
  swc_host_state_type   state_q;
  swc_host_state_type   state_d;
  logic [7:0]           byte_q;
  logic                 rx_wait_q;
  logic                 ind_prev_q;
  logic                 attn_prev_q;
  logic [SETTLE_W-1:0]  settle_q;
  logic                 sleep_rq_q;
  logic                 select_n_q;
  logic                 hold;
  logic                 ready;
  logic                 pend_event;

  assign hold       = (state_q != H_IDLE) || rx_wait_q;
  assign send_ready = (state_q == H_IDLE);
  // status lines alone are not enough: wait for the module to settle awake
  assign ready = (settle_q == SETTLE_DONE) &&
                 (spi_mode || (link.awake_indicator && !link.cts_n));
  // pending data shows as a rising status line or falling attention
  assign pend_event = spi_mode ? (attn_prev_q && !link.attention_n)
                               : (!ind_prev_q && link.awake_indicator && sleep_rq_q);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      H_IDLE: if (send_valid) state_d = H_WAKE;
      H_WAKE: if (ready) state_d = H_SEND;
      H_SEND: state_d = H_IDLE;
      default: state_d = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) state_q <= H_IDLE;
    else state_q <= state_d;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) byte_q <= BYTE_ZERO;
    else if (send_valid && send_ready) byte_q <= send_byte;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ind_prev_q  <= 1'b0;
      attn_prev_q <= 1'b1;
    end
    else
    begin
      ind_prev_q  <= link.awake_indicator;
      attn_prev_q <= link.attention_n;
    end
  end

  // keep select and wake until the byte is out; set wins
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) rx_wait_q <= 1'b0;
    else if (pend_event) rx_wait_q <= 1'b1;
    else if (link.dev_data_valid) rx_wait_q <= 1'b0;
  end

  // high asks sleep, low wakes; spi also asserts select
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sleep_rq_q <= 1'b0;
      select_n_q <= 1'b1;
    end
    else
    begin
      sleep_rq_q <= want_sleep && !hold;
      select_n_q <= !(spi_mode && (hold || (select_sleeps && !want_sleep)));
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) settle_q <= SETTLE_ZERO;
    else if (state_q != H_WAKE || sleep_rq_q) settle_q <= SETTLE_ZERO;
    else if (settle_q != SETTLE_DONE) settle_q <= settle_q + SETTLE_ONE;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      recv_valid <= 1'b0;
      recv_byte  <= BYTE_ZERO;
    end
    else
    begin
      recv_valid <= link.dev_data_valid;
      if (link.dev_data_valid) recv_byte <= link.dev_data;
    end
  end

  assign link.sleep_request_in = sleep_rq_q;
  assign link.serial_select_n  = select_n_q;
  assign link.host_data_valid  = (state_q == H_SEND);
  assign link.host_data        = byte_q;
endmodule

// ===== rtl/swc_device.sv
// wireless module end: sleep state machine, status pins, wake timing
// Functional notes
// - awake indicator low asleep, high awake; code also drives it high asleep while radio data is pending
// - cts high entering sleep, low waking
// - ignore serial and radio data asleep
// - uart pin sleep needs request pin configured
// - host drives request high sleep, low wake
// - spi attention and status message after init
// - request pin if peripheral, else slave select
// - negated slave select puts to sleep only if request pin not peripheral
// - associated pin sleep wakes each dtim, hidden
// - deliver pending data only after pin deasserts
// - attention on data; host clocks it out
// - host data accepted, queued until next dtim
// - spi request sleep needs select and deassert
// - cyclic check window 30 ms within wake
// - deep pin sleep powers radio down, rejoins
// - previously associated ready within 160 ms
// - deep cyclic wake counts after association
// - association timeout sleeps anyway, retries next
// - wake time over interval plus one samples
// - uart output and samples wait host delay
// - status outputs not delayed by host delay
// - deep sleep samples need delay and association
`timescale 1ns/1ps
module swc_device
  import swc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF  // clocks per millisecond tick
)
(
  input  wire logic               clk,                      // 125 MHz clock
  input  wire logic               resetn,                   // async reset, low active
  swc_if.device                   link,                     // pins to the host
  input  wire logic               spi_mode,                 // serial link is spi
  input  wire logic [1:0]         sleep_selection,          // none, pin or cyclic
  input  wire logic               sleep_option,             // associated or deep
  input  wire logic [2:0]         status_pin_config,        // awake pin function
  input  wire logic [2:0]         flow_control_pin_config,  // cts pin function
  input  wire logic [2:0]         sleep_request_pin_config, // request pin function
  input  wire logic [TIMER_W-1:0] sleep_period,             // ms asleep, cyclic
  input  wire logic [TIMER_W-1:0] wake_time,                // ms awake, cyclic
  input  wire logic [TIMER_W-1:0] association_timeout,      // ms to wait for join
  input  wire logic [TIMER_W-1:0] sample_interval,          // ms between samples
  input  wire logic [TIMER_W-1:0] host_wake_delay,          // ms before output
  input  wire logic               sample_enable,            // sampling on wake
  input  wire logic               beacon_dtim,              // radio dtim pulse
  input  wire logic               associated_in,            // radio is joined
  input  wire logic               radio_rx_valid,           // radio byte in
  input  wire logic [7:0]         radio_rx_byte,            // radio byte
  output logic                    radio_tx_valid,           // byte to radio
  output logic [7:0]              radio_tx_byte,            // byte to radio
  output logic                    radio_power_en,           // radio powered
  output logic                    start_association,        // join request pulse
  output logic                    rejoin_fast,              // joined before sleep
  output logic                    rejoin_late,              // fast rejoin overran
  output logic                    sample_strobe,            // take one sample
  output logic                    modem_status,             // status message pulse
  output logic                    asleep                    // internal sleep state
);
  swc_dev_state_type    state_q;
  swc_dev_state_type    state_d;
  logic [TICK_W-1:0]    tick_q;
  logic                 ms_tick;
  logic [TIMER_W-1:0]   cycle_ms_q;
  logic [TIMER_W-1:0]   since_wake_ms_q;
  logic [TIMER_W-1:0]   iv_ms_q;
  logic [OWED_W-1:0]    owed_q;
  logic                 rx_pend_q;
  logic [7:0]           rx_byte_q;
  logic                 tx_queued_q;
  logic                 init_attn_q;
  logic                 was_assoc_q;
  logic                 ind_q;
  logic                 cts_n_q;
  logic                 attn_n_q;
  logic                 dev_valid_q;
  logic                 sel_pin;
  logic                 sel_cyc;
  logic                 deep;
  logic                 pin_level;
  logic                 activity;
  logic                 awake_d;
  logic                 awake_now;
  logic                 woke;
  logic                 delay_done;
  logic                 deliver;
  logic                 take_sample;
  logic                 iv_hit;
  logic                 host_take;
  logic                 queue_tx;
  logic                 cycle_restart;

  // selection and option are plain configuration inputs
  assign sel_pin = (sleep_selection == SEL_PIN);
  assign sel_cyc = (sleep_selection == SEL_CYCLIC);
  assign deep    = (sleep_option == OPT_DEEP);
  // request pin if peripheral, else select in spi, else never
  assign pin_level = (sleep_request_pin_config == PIN_PERIPHERAL) ? link.sleep_request_in :
                     (spi_mode ? link.serial_select_n : 1'b0);
  assign activity  = radio_rx_valid || link.host_data_valid;
  assign ms_tick   = (tick_q == TICK_W'(TICK_CYCLES - 1));

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_INIT: state_d = ST_AWAKE;
      ST_AWAKE:
        if (sel_pin && pin_level) state_d = ST_SLEEP;
        else if (sel_cyc) state_d = deep ? ST_ASSOC : ST_WAKE;
      ST_SLEEP:
        if (sel_pin)
        begin
          // deasserting the pin wakes and rejoins in deep sleep
          if (!pin_level) state_d = ST_AWAKE;
          // hidden wake at each dtim in associated sleep
          else if (!deep && beacon_dtim) state_d = ST_DTIM;
        end
        else if (sel_cyc)
        begin
          if (ms_tick && (cycle_ms_q + MS_ONE) >= sleep_period)
            state_d = deep ? ST_ASSOC : ST_CHECK;
        end
        else state_d = ST_AWAKE;
      ST_DTIM: state_d = ST_SLEEP;
      ST_CHECK:
        // activity in the window keeps the full wake time
        if (!sel_cyc) state_d = ST_AWAKE;
        else if (activity) state_d = ST_WAKE;
        else if (cycle_ms_q >= CHECK_MS) state_d = ST_SLEEP;
      ST_WAKE:
        // wake time is not restarted by later activity
        if (!sel_cyc) state_d = ST_AWAKE;
        else if (cycle_ms_q >= wake_time) state_d = ST_SLEEP;
      ST_ASSOC:
        // join first, timeout sleeps and retries next wake
        if (!sel_cyc) state_d = ST_AWAKE;
        else if (associated_in) state_d = ST_WAKE;
        else if (cycle_ms_q >= association_timeout) state_d = ST_SLEEP;
      default: state_d = ST_INIT;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) state_q <= ST_INIT;
    else state_q <= state_d;
  end

  assign awake_now = (state_q == ST_AWAKE) || (state_q == ST_CHECK) ||
                     (state_q == ST_WAKE) || (state_q == ST_ASSOC);
  assign awake_d   = (state_d == ST_AWAKE) || (state_d == ST_CHECK) ||
                     (state_d == ST_WAKE) || (state_d == ST_ASSOC);
  assign woke      = awake_d && !awake_now;
  // the check window flows into the wake time, so that move keeps the count
  assign cycle_restart = (state_d != state_q) &&
                         !(state_q == ST_CHECK && state_d == ST_WAKE);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) tick_q <= TICK_ZERO;
    else if (ms_tick) tick_q <= TICK_ZERO;
    else tick_q <= tick_q + TICK_ONE;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) cycle_ms_q <= MS_ZERO;
    else if (cycle_restart) cycle_ms_q <= MS_ZERO;
    else if (ms_tick && cycle_ms_q != '1) cycle_ms_q <= cycle_ms_q + MS_ONE;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) since_wake_ms_q <= MS_ZERO;
    else if (woke) since_wake_ms_q <= MS_ZERO;
    else if (ms_tick && since_wake_ms_q != '1) since_wake_ms_q <= since_wake_ms_q + MS_ONE;
  end

  // output and sampling held until the host delay has run
  assign delay_done = awake_now && (since_wake_ms_q >= host_wake_delay);
  assign iv_hit     = ms_tick && (sample_interval != MS_ZERO) &&
                      ((iv_ms_q + MS_ONE) >= sample_interval);
  // deep sleep also waits for association before sampling
  assign take_sample = sample_enable && delay_done && (owed_q != OWED_ZERO) &&
                       (!deep || associated_in);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) iv_ms_q <= MS_ZERO;
    else if (woke || iv_hit) iv_ms_q <= MS_ZERO;
    else if (ms_tick) iv_ms_q <= iv_ms_q + MS_ONE;
  end

  // one sample at wake plus one per interval; owed count saturates
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) owed_q <= OWED_ZERO;
    else if (!sample_enable) owed_q <= OWED_ZERO;
    else if (woke) owed_q <= OWED_ONE;
    else if (!awake_now) owed_q <= OWED_ZERO;
    else if (iv_hit && !take_sample && owed_q != OWED_MAX) owed_q <= owed_q + OWED_ONE;
    else if (take_sample && !iv_hit) owed_q <= owed_q - OWED_ONE;
  end

  // radio bytes only taken while awake or at a dtim
  // delivery waits for the pin release and, in spi, the select
  assign deliver = rx_pend_q && delay_done && (!spi_mode || !link.serial_select_n);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_pend_q <= 1'b0;
      rx_byte_q <= BYTE_ZERO;
    end
    else if (radio_rx_valid && (awake_now || state_q == ST_DTIM))
    begin
      rx_pend_q <= 1'b1;
      rx_byte_q <= radio_rx_byte;
    end
    else if (deliver) rx_pend_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn) dev_valid_q <= 1'b0;
    else dev_valid_q <= deliver;
  end

  // host bytes taken only while awake
  // in associated pin sleep a byte waits for the next dtim
  assign host_take = link.host_data_valid && awake_now;
  assign queue_tx  = sel_pin && !deep;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_queued_q    <= 1'b0;
      radio_tx_valid <= 1'b0;
      radio_tx_byte  <= BYTE_ZERO;
    end
    else
    begin
      radio_tx_valid <= (host_take && !queue_tx) || (tx_queued_q && beacon_dtim);
      if (host_take) radio_tx_byte <= link.host_data;
      if (host_take && queue_tx) tx_queued_q <= 1'b1;
      else if (beacon_dtim) tx_queued_q <= 1'b0;
    end
  end

  // radio off in deep sleep, join request on each deep wake
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      radio_power_en    <= 1'b1;
      start_association <= 1'b0;
    end
    else
    begin
      radio_power_en    <= !(deep && state_d == ST_SLEEP);
      start_association <= deep && state_q == ST_SLEEP && woke;
    end
  end

  // a prior join should come back within the rejoin bound
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      was_assoc_q <= 1'b0;
      rejoin_fast <= 1'b0;
      rejoin_late <= 1'b0;
    end
    else
    begin
      if (deep && state_d == ST_SLEEP && state_q != ST_SLEEP) was_assoc_q <= associated_in;
      if (deep && state_q == ST_SLEEP && woke) rejoin_fast <= was_assoc_q;
      else if (associated_in || !awake_now) rejoin_fast <= 1'b0;
      if (woke) rejoin_late <= 1'b0;
      else if (rejoin_fast && since_wake_ms_q >= REJOIN_TMO) rejoin_late <= 1'b1;
    end
  end

  // spi attention and status message once initialised
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      init_attn_q  <= 1'b0;
      modem_status <= 1'b0;
    end
    else
    begin
      modem_status <= spi_mode && state_q == ST_INIT;
      if (spi_mode && state_q == ST_INIT) init_attn_q <= 1'b1;
      else if (!link.serial_select_n) init_attn_q <= 1'b0;
    end
  end

  // status pins follow wake or pending data, never delayed
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ind_q    <= 1'b0;
      cts_n_q  <= 1'b1;
      attn_n_q <= 1'b1;
      asleep   <= 1'b0;
    end
    else
    begin
      ind_q    <= (status_pin_config == PIN_PERIPHERAL) && (awake_d || rx_pend_q);
      cts_n_q  <= (flow_control_pin_config == PIN_PERIPHERAL) && !(awake_d || rx_pend_q);
      // attention marks data waiting for the spi master
      attn_n_q <= !(spi_mode && (init_attn_q || rx_pend_q));
      asleep   <= !awake_d;
    end
  end

  assign sample_strobe        = take_sample;
  assign link.awake_indicator = ind_q;
  assign link.cts_n           = cts_n_q;
  assign link.attention_n     = attn_n_q;
  assign link.dev_data_valid  = dev_valid_q;
  assign link.dev_data        = rx_byte_q;
endmodule

// ===== dv/swc_link_sva.sv
// pin-level checks between host and module ends
`timescale 1ns/1ps
module swc_link_sva (
  input wire logic       clk,              // clock
  input wire logic       resetn,           // async reset, low active
  input wire logic       sleep_request_in, // host sleep request
  input wire logic       serial_select_n,  // slave select
  input wire logic       awake_indicator,  // high while awake
  input wire logic       cts_n,            // clear to send
  input wire logic       attention_n,      // spi attention
  input wire logic       host_data_valid,  // host byte strobe
  input wire logic [7:0] host_data,        // host byte
  input wire logic       dev_data_valid,   // module byte strobe
  input wire logic [7:0] dev_data          // module byte
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // holds for a uart link with status and flow pins configured only
  status_pair_a: assert property (awake_indicator != cts_n)
    else $error("awake indicator and cts disagree");
  sleep_drop_a: assert property ($rose(sleep_request_in) |-> ##[1:2] !awake_indicator)
    else $error("indicator stayed high after sleep request");
  wake_rise_a: assert property ($fell(sleep_request_in) |-> ##[1:2] awake_indicator)
    else $error("indicator late after wake request");
  deliver_awake_a: assert property (dev_data_valid |-> !$past(sleep_request_in))
    else $error("data delivered while sleep pin high");
  send_awake_a: assert property (host_data_valid |-> awake_indicator && !cts_n)
    else $error("host sent while module not ready");
  host_pulse_a: assert property (host_data_valid |=> !host_data_valid)
    else $error("host strobe longer than one cycle");
  dev_pulse_a: assert property (dev_data_valid |=> !dev_data_valid)
    else $error("module strobe longer than one cycle");
  attn_idle_a: assert property (attention_n)
    else $error("attention raised on uart link");
endmodule

// ===== dv/test_sleep_wake_controller.sv
// bench joining host and module ends over the pin interface
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %0t got %h expected %h", $time, g, e); end end
module test_sleep_wake_controller
  import swc_pkg::*;
;
  logic       clk, resetn, want_sleep, send_valid, beacon_dtim, radio_rx_valid, seen;
  logic [7:0] send_byte, radio_rx_byte, recv_byte, radio_tx_byte;
  logic       send_ready, recv_valid, radio_tx_valid, asleep, radio_power_en, sample_strobe;
  logic       select_sleeps, sample_enable, associated_in;
  logic [1:0] sleep_selection;
  logic [2:0] pin_config;
  logic [TIMER_W-1:0] period_ms, sample_interval, host_wake_delay;
  int         err_total, check_count, strobes;

  swc_if i_swc_if ();
  swc_host i_swc_host (.clk(clk), .resetn(resetn), .link(i_swc_if), .spi_mode(1'b0),
    .select_sleeps(select_sleeps), .want_sleep(want_sleep), .send_valid(send_valid),
    .send_byte(send_byte), .send_ready(send_ready), .recv_valid(recv_valid),
    .recv_byte(recv_byte));
  swc_device #(.TICK_CYCLES(4)) i_swc_device (.clk(clk), .resetn(resetn), .link(i_swc_if),
    .spi_mode(1'b0), .sleep_selection(sleep_selection), .sleep_option(OPT_ASSOC),
    .status_pin_config(pin_config), .flow_control_pin_config(pin_config),
    .sleep_request_pin_config(pin_config), .sleep_period(period_ms), .wake_time(period_ms),
    .association_timeout(period_ms), .sample_interval(sample_interval),
    .host_wake_delay(host_wake_delay), .sample_enable(sample_enable),
    .beacon_dtim(beacon_dtim), .associated_in(associated_in),
    .radio_rx_valid(radio_rx_valid), .radio_rx_byte(radio_rx_byte),
    .radio_tx_valid(radio_tx_valid), .radio_tx_byte(radio_tx_byte),
    .radio_power_en(radio_power_en),
    .start_association(), .rejoin_fast(), .rejoin_late(), .sample_strobe(sample_strobe),
    .modem_status(), .asleep(asleep));
  swc_link_sva i_swc_link_sva (.clk(clk), .resetn(resetn),
    .sleep_request_in(i_swc_if.sleep_request_in), .serial_select_n(i_swc_if.serial_select_n),
    .awake_indicator(i_swc_if.awake_indicator), .cts_n(i_swc_if.cts_n),
    .attention_n(i_swc_if.attention_n), .host_data_valid(i_swc_if.host_data_valid),
    .host_data(i_swc_if.host_data), .dev_data_valid(i_swc_if.dev_data_valid),
    .dev_data(i_swc_if.dev_data));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic final_report();
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // bounded wait for the awake indicator to reach a level
  task automatic wait_ind(input logic lvl);
    int k;
    k = 0;
    while (i_swc_if.awake_indicator !== lvl && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    if (i_swc_if.awake_indicator !== lvl)
    begin
      err_total++;
      $display("ERROR %0t indicator never settled", $time);
      final_report();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // bounded wait for a one-cycle pulse: 0 host receive, 1 radio send
  task automatic wait_pulse(input int which);
    int k;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while ((which == 0 ? recv_valid : radio_tx_valid) !== 1'b1 && k < 200);
    if ((which == 0 ? recv_valid : radio_tx_valid) !== 1'b1)
    begin
      err_total++;
      $display("ERROR %0t pulse never came", $time);
      final_report();
    end
  endtask

  initial
  begin
    err_total = 0;
    check_count = 0;
    resetn = 1'b0;
    want_sleep = 1'b0;
    send_valid = 1'b0;
    send_byte = BYTE_ZERO;
    beacon_dtim = 1'b0;
    radio_rx_valid = 1'b0;
    radio_rx_byte = BYTE_ZERO;
    select_sleeps = 1'b0;
    sample_enable = 1'b1;
    associated_in = 1'b1;
    sleep_selection = SEL_PIN;
    pin_config = PIN_PERIPHERAL;
    period_ms = MS_ONE;
    sample_interval = MS_ZERO;
    host_wake_delay = 16'h0002;
    cyc(8);
    resetn <= 1'b1;
    cyc(4);
    @(negedge clk);
    `CHK(i_swc_if.awake_indicator, 1'b1)
    `CHK(i_swc_if.cts_n, 1'b0)
    @(posedge clk);
    want_sleep <= 1'b1;
    cyc(4);
    @(negedge clk);
    `CHK(i_swc_if.awake_indicator, 1'b0)
    `CHK(i_swc_if.cts_n, 1'b1)
    // radio byte outside any beacon must be dropped
    @(posedge clk);
    radio_rx_valid <= 1'b1;
    radio_rx_byte <= 8'h5A;
    @(posedge clk);
    radio_rx_valid <= 1'b0;
    cyc(3);
    @(negedge clk);
    `CHK(i_swc_if.awake_indicator, 1'b0)
    // byte held over two cycles so it meets the hidden beacon cycle
    @(posedge clk);
    beacon_dtim <= 1'b1;
    radio_rx_valid <= 1'b1;
    radio_rx_byte <= 8'hC3;
    @(posedge clk);
    beacon_dtim <= 1'b0;
    @(posedge clk);
    radio_rx_valid <= 1'b0;
    cyc(2);
    @(negedge clk);
    `CHK(i_swc_if.awake_indicator, 1'b1)
    @(posedge clk);
    want_sleep <= 1'b0;
    wait_pulse(0);
    `CHK(recv_byte, 8'hC3)
    @(posedge clk);
    want_sleep <= 1'b1;
    cyc(6);
    send_valid <= 1'b1;
    send_byte <= 8'h96;
    @(posedge clk);
    send_valid <= 1'b0;
    seen = 1'b0;
    repeat (20)
    begin
      @(negedge clk);
      seen = seen | radio_tx_valid;
    end
    `CHK(seen, 1'b0)
    @(posedge clk);
    beacon_dtim <= 1'b1;
    @(posedge clk);
    beacon_dtim <= 1'b0;
    wait_pulse(1);
    `CHK(radio_tx_byte, 8'h96)
    // cyclic: awake through the first 25 ms of the 30 ms check window; periodic sampling off, one sample
    @(posedge clk);
    sleep_selection <= SEL_CYCLIC;
    wait_ind(1'b1);
    seen = 1'b0;
    strobes = 0;
    repeat (100)
    begin
      @(negedge clk);
      seen = seen | !i_swc_if.awake_indicator;
      strobes += int'(sample_strobe);
    end
    `CHK(seen, 1'b0)
    `CHK(strobes, 1)
    wait_ind(1'b0);
    `CHK(asleep, 1'b1)
    `CHK(radio_power_en, 1'b1)
    final_report();
  end
endmodule
